/* core/fsag_guard.sv */
// flash security access guard: judges each flash request, owns the
// program-store and supply-monitor controls, and raises device resets
// assumes an AXI4-Lite master and a flash that shows its lock byte
//
// Design decisions made here: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module fsag_guard #(
  parameter int ADDR_W = fsag_pkg::ADDR_W
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic reqValid,
  input wire logic reqFromDebug,
  input wire logic [1:0] reqOp,
  input wire logic [ADDR_W-1:0] reqAddr,
  input wire logic [7:0] reqData,
  input wire logic [ADDR_W-1:0] fetchAddr,
  input wire logic [7:0] lockByteStored,
  input wire logic flashBusy,
  output logic respValid,
  output logic respPermit,
  output logic respDrop,
  output logic wholeEraseGo,
  output logic irqHold,
  output logic deviceReset
);
  // ------------------------------------------------------------
  // verdict
  // ------------------------------------------------------------
  function automatic fsag_pkg::fsag_verdict_t decide(
    input logic fromDebug,
    input logic fwLocked,
    input logic anyLocked,
    input logic lbWritten,
    input logic supplyOk,
    input fsag_pkg::fsag_region_t rg,
    input fsag_pkg::fsag_op_t op
  );
    fsag_pkg::fsag_verdict_t deny;
    logic lockPage;
    deny = fromDebug ? fsag_pkg::V_DROP : fsag_pkg::V_RESET;
    lockPage = rg == fsag_pkg::RG_LBPAGE || rg == fsag_pkg::RG_LBYTE;
    decide = fsag_pkg::V_PERMIT;
    if (op == fsag_pkg::OP_DEV_ERASE) begin
      decide = fromDebug ? fsag_pkg::V_PERMIT : fsag_pkg::V_RESET;
    end else if (rg == fsag_pkg::RG_RSVD) begin
      decide = deny;
    end else if (!fromDebug && op != fsag_pkg::OP_READ && !supplyOk) begin
      decide = fsag_pkg::V_RESET;
    end else if (op == fsag_pkg::OP_ERASE && lockPage) begin
      decide = (fromDebug && !anyLocked) ? fsag_pkg::V_PERMIT : deny;
    end else if (rg == fsag_pkg::RG_LBYTE && op == fsag_pkg::OP_WRITE && lbWritten) begin
      decide = deny;
    end else if (rg == fsag_pkg::RG_LOCKED || (lockPage && anyLocked)) begin
      decide = (!fromDebug && fwLocked) ? fsag_pkg::V_PERMIT : deny;
    end
  endfunction

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  logic loadDone_reg;
  logic [7:0] actLock_reg;
  logic [7:0] pendLock_reg;
  logic [1:0] psc_reg;
  logic [1:0] vmon_reg;
  logic ferr_reg;
  logic [3:0] awAddr_reg;
  logic [31:0] wData_reg;
  logic [3:0] wStrb_reg;
  fsag_pkg::fsag_region_t reqRegion;
  fsag_pkg::fsag_verdict_t verdict;
  fsag_pkg::fsag_op_t op;
  logic fetchLocked;
  logic anyLocked;
  logic lbWritten;
  logic supplyOk;
  logic fwNoEnable;
  logic accept;
  logic errRstEvt;
  logic devEraseOk;
  logic lbWriteOk;
  logic doWrite;
  logic devRstW;

  assign op = fsag_pkg::fsag_op_t'(reqOp);
  assign anyLocked = actLock_reg != fsag_pkg::LOCK_OPEN;
  assign lbWritten = pendLock_reg != fsag_pkg::LOCK_OPEN;
  assign supplyOk = vmon_reg[fsag_pkg::VMON_EN_BIT] && vmon_reg[fsag_pkg::VMON_RST_BIT];

  fsag_region_decode #(.ADDR_W(ADDR_W)) u_reqDecode (
    .addr(reqAddr),
    .lockByte(actLock_reg),
    .region(reqRegion),
    .inLocked()
  );

  fsag_region_decode #(.ADDR_W(ADDR_W)) u_fetchDecode (
    .addr(fetchAddr),
    .lockByte(actLock_reg),
    .region(),
    .inLocked(fetchLocked)
  );

  // firmware stores without the enables land in data memory, not flash
  assign fwNoEnable = !reqFromDebug &&
    ((op == fsag_pkg::OP_WRITE && !psc_reg[fsag_pkg::WR_EN_BIT]) ||
     (op == fsag_pkg::OP_ERASE && psc_reg != 2'h3));
  assign accept = reqValid && loadDone_reg && !devRstW && !fwNoEnable;
  assign verdict = decide(reqFromDebug, fetchLocked, anyLocked, lbWritten, supplyOk, reqRegion, op);
  assign errRstEvt = accept && verdict == fsag_pkg::V_RESET;
  assign devEraseOk = accept && verdict == fsag_pkg::V_PERMIT && op == fsag_pkg::OP_DEV_ERASE;
  assign lbWriteOk = accept && verdict == fsag_pkg::V_PERMIT &&
    op == fsag_pkg::OP_WRITE && reqRegion == fsag_pkg::RG_LBYTE;

  fsag_reset_pulse u_resetPulse (
    .ref_clk(ref_clk),
    .rst(rst),
    .trig(errRstEvt),
    .pulse(devRstW)
  );
  assign deviceReset = devRstW;

  // ------------------------------------------------------------
  // lock byte tracking
  // ------------------------------------------------------------
  // the stored lock byte is caught once after release, never at reset
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      loadDone_reg <= 1'b0;
    end else begin
      loadDone_reg <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pendLock_reg <= fsag_pkg::LOCK_OPEN;
    end else if (!loadDone_reg) begin
      pendLock_reg <= lockByteStored;
    end else if (devEraseOk) begin
      pendLock_reg <= fsag_pkg::LOCK_OPEN;
    end else if (lbWriteOk) begin
      pendLock_reg <= pendLock_reg & reqData; // flash only clears bits
    end
  end

  // active lock follows the pending value only across a device reset
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      actLock_reg <= fsag_pkg::LOCK_OPEN;
    end else if (!loadDone_reg) begin
      actLock_reg <= lockByteStored;
    end else if (devEraseOk) begin
      actLock_reg <= fsag_pkg::LOCK_OPEN;
    end else if (errRstEvt) begin
      actLock_reg <= pendLock_reg;
    end
  end

  // ------------------------------------------------------------
  // request answer
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      respValid <= 1'b0;
      respPermit <= 1'b0;
      respDrop <= 1'b0;
      wholeEraseGo <= 1'b0;
    end else begin
      respValid <= reqValid;
      respPermit <= accept && verdict == fsag_pkg::V_PERMIT;
      respDrop <= reqValid && !(accept && verdict != fsag_pkg::V_DROP);
      wholeEraseGo <= devEraseOk;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      irqHold <= 1'b0;
    end else begin
      irqHold <= flashBusy;
    end
  end

  // ------------------------------------------------------------
  // control registers
  // ------------------------------------------------------------
  assign doWrite = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      psc_reg <= fsag_pkg::PSC_RESET;
    end else if (errRstEvt) begin
      psc_reg <= fsag_pkg::PSC_RESET;
    end else if (doWrite && awAddr_reg == fsag_pkg::OFF_STORE_CTL && wStrb_reg[0]) begin
      psc_reg <= wData_reg[1:0];
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      vmon_reg <= fsag_pkg::VMON_RESET;
    end else if (errRstEvt) begin
      vmon_reg <= fsag_pkg::VMON_RESET;
    end else if (doWrite && awAddr_reg == fsag_pkg::OFF_RSRC && wStrb_reg[0]) begin
      vmon_reg <= wData_reg[1:0];
    end
  end

  // survives the device reset it causes; only rst clears it
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ferr_reg <= 1'b0;
    end else if (errRstEvt) begin
      ferr_reg <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // axi4-lite write path
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s_axi_awready <= 1'b1;
      awAddr_reg <= 4'h0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      s_axi_awready <= 1'b0;
      awAddr_reg <= s_axi_awaddr;
    end else if (doWrite) begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s_axi_wready <= 1'b1;
      wData_reg <= 32'h0000_0000;
      wStrb_reg <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      s_axi_wready <= 1'b0;
      wData_reg <= s_axi_wdata;
      wStrb_reg <= s_axi_wstrb;
    end else if (doWrite) begin
      s_axi_wready <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= fsag_pkg::RESP_OKAY;
    end else if (doWrite) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (awAddr_reg == fsag_pkg::OFF_STORE_CTL || awAddr_reg == fsag_pkg::OFF_RSRC ||
        awAddr_reg == fsag_pkg::OFF_STAT) ? fsag_pkg::RESP_OKAY : fsag_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // axi4-lite read path
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= fsag_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= fsag_pkg::RESP_OKAY;
      case (s_axi_araddr)
        fsag_pkg::OFF_STORE_CTL: begin
          s_axi_rdata <= {30'h0, psc_reg};
        end
        fsag_pkg::OFF_RSRC: begin
          s_axi_rdata <= {25'h0, ferr_reg, 4'h0, vmon_reg};
        end
        fsag_pkg::OFF_STAT: begin
          s_axi_rdata <= {15'h0, anyLocked, pendLock_reg, actLock_reg};
        end
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= fsag_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  sequence s_fwReq;
    accept && !reqFromDebug;
  endsequence

  sequence s_errThenReset;
    ##1 deviceReset && !respPermit ##1 deviceReset;
  endsequence

  property p_unlockedOpen;
    accept && reqRegion == fsag_pkg::RG_UNLOCKED && op != fsag_pkg::OP_DEV_ERASE &&
      (reqFromDebug || op == fsag_pkg::OP_READ || supplyOk) |=> respPermit;
  endproperty
  a_unlockedOpen: assert property (p_unlockedOpen) else $error("unlocked access refused");

  property p_lockedFromUnlocked;
    s_fwReq and (reqRegion == fsag_pkg::RG_LOCKED && !fetchLocked) |-> s_errThenReset;
  endproperty
  a_lockedFromUnlocked: assert property (p_lockedFromUnlocked) else $error("no reset on locked access");

  property p_debugLockedDrop;
    accept && reqFromDebug && anyLocked && reqRegion == fsag_pkg::RG_LBPAGE &&
      op != fsag_pkg::OP_DEV_ERASE |=> respDrop && !respPermit;
  endproperty
  a_debugLockedDrop: assert property (p_debugLockedDrop) else $error("debug reached locked lock page");

  property p_fwEraseLockPage;
    s_fwReq and (op == fsag_pkg::OP_ERASE && reqRegion == fsag_pkg::RG_LBPAGE) |-> s_errThenReset;
  endproperty
  a_fwEraseLockPage: assert property (p_fwEraseLockPage) else $error("firmware erased lock page");

  property p_debugNoReset;
    reqValid && reqFromDebug && !deviceReset |=> !deviceReset;
  endproperty
  a_debugNoReset: assert property (p_debugNoReset) else $error("debug request reset the device");

  property p_flagAfterReset;
    errRstEvt |=> ferr_reg [*3];
  endproperty
  a_flagAfterReset: assert property (p_flagAfterReset) else $error("error flag not held");

  property p_wholeErase;
    devEraseOk |=> wholeEraseGo && actLock_reg == fsag_pkg::LOCK_OPEN && pendLock_reg == fsag_pkg::LOCK_OPEN;
  endproperty
  a_wholeErase: assert property (p_wholeErase) else $error("device erase left a lock");

  property p_lockDeferred;
    lbWriteOk |=> $stable(actLock_reg);
  endproperty
  a_lockDeferred: assert property (p_lockDeferred) else $error("lock applied before reset");

  property p_lockWrittenOnce;
    accept && lbWritten && op == fsag_pkg::OP_WRITE && reqRegion == fsag_pkg::RG_LBYTE |=>
      !respPermit && $stable(pendLock_reg);
  endproperty
  a_lockWrittenOnce: assert property (p_lockWrittenOnce) else $error("lock byte rewritten");

  property p_supply;
    s_fwReq and (op == fsag_pkg::OP_WRITE && !supplyOk && reqRegion != fsag_pkg::RG_RSVD) |-> ##1 deviceReset;
  endproperty
  a_supply: assert property (p_supply) else $error("write without supply monitor");

  property p_reservedDebug;
    accept && reqFromDebug && reqRegion == fsag_pkg::RG_RSVD && op != fsag_pkg::OP_DEV_ERASE |=>
      respDrop && !deviceReset;
  endproperty
  a_reservedDebug: assert property (p_reservedDebug) else $error("debug reached reserved area");

  property p_irqHold;
    flashBusy |=> irqHold;
  endproperty
  a_irqHold: assert property (p_irqHold) else $error("interrupts not held");
endmodule
`default_nettype wire

/* common/fsag_pkg.sv */
// constants, codes and types shared by the flash security access guard
// assumes a 25 MHz system clock and a 16 kB flash with 512-byte pages
//
// Overview of operation
// - unlocked pages open to every requester
// - locked pages: debug dropped, unlocked firmware resets
// - lock-byte page shared until any page locks
// - lock byte readable by all until locking
// - unlocked: only debug may erase lock page
// - locked: only whole-device erase clears lock page
// - clearing lock-byte bits: debug dropped, firmware resets (the guard permits it while the lock byte is still unwritten)
// - setting lock-byte bits: debug dropped, firmware resets
// - reserved area: debug dropped, firmware resets
// - whole-device erase wipes all pages, lock included
// - firmware denial resets device, sets error flag
// - debug denials are dropped, never reset
// - any lock also locks the lock-byte page
// - written lock byte changes only by device erase
// - new lock state applies after next reset
// - firmware modify needs supply monitor and reset
// - interrupts held off during flash operation
// - store write enable is control bit 0
// - locked page count is lock byte complement
// - lock byte is last user flash byte
// - reserved area spans 0x3e00 to 0x3fff
package fsag_pkg;
  // ------------------------------------------------------------
  // flash map
  // ------------------------------------------------------------
  localparam int ADDR_W = 14;
  localparam int PAGE_SHIFT = 9;
  localparam logic [13:0] LOCK_BYTE_ADDR = 14'h3dff;
  localparam logic [4:0] LOCK_PAGE = LOCK_BYTE_ADDR[13:9];
  localparam logic [13:0] RSVD_LO = 14'h3e00;
  localparam logic [13:0] RSVD_HI = 14'h3fff;
  localparam logic [7:0] LOCK_OPEN = 8'hff;
  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam logic [3:0] OFF_STORE_CTL = 4'h0;
  localparam logic [3:0] OFF_RSRC = 4'h4;
  localparam logic [3:0] OFF_STAT = 4'h8;
  localparam int WR_EN_BIT = 0;
  localparam int ER_EN_BIT = 1;
  localparam int VMON_EN_BIT = 0;
  localparam int VMON_RST_BIT = 1;
  localparam int FERR_BIT = 6;
  localparam int STAT_ANY_BIT = 16;
  localparam logic [1:0] PSC_RESET = 2'h0;
  localparam logic [1:0] VMON_RESET = 2'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CLK_MHZ = 25;
  localparam int RESET_PULSE_NS = 160;
  localparam int RESET_PULSE_CYC = (RESET_PULSE_NS * CLK_MHZ + 999) / 1000;
  // ------------------------------------------------------------
  // codes
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    OP_READ = 2'h0,
    OP_WRITE = 2'h1,
    OP_ERASE = 2'h2,
    OP_DEV_ERASE = 2'h3
  } fsag_op_t;
  typedef enum logic [4:0] {
    RG_UNLOCKED = 5'h01,
    RG_LOCKED = 5'h02,
    RG_LBPAGE = 5'h04,
    RG_LBYTE = 5'h08,
    RG_RSVD = 5'h10
  } fsag_region_t;
  typedef enum logic [2:0] {
    V_PERMIT = 3'h1,
    V_DROP = 3'h2,
    V_RESET = 3'h4
  } fsag_verdict_t;
endpackage

/* core/fsag_region_decode.sv */
// classifies one flash address against the active lock byte
// assumes a byte address inside the 16 kB flash
`timescale 1ns/1ps
`default_nettype none
module fsag_region_decode #(
  parameter int ADDR_W = fsag_pkg::ADDR_W
) (
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [7:0] lockByte,
  output var fsag_pkg::fsag_region_t region,
  output logic inLocked
);
  logic [ADDR_W-fsag_pkg::PAGE_SHIFT-1:0] pageIdx;
  logic anyLocked;

  assign pageIdx = addr[ADDR_W-1:fsag_pkg::PAGE_SHIFT];
  assign anyLocked = lockByte != fsag_pkg::LOCK_OPEN;

  always_comb begin
    if (addr >= fsag_pkg::RSVD_LO && addr <= fsag_pkg::RSVD_HI) begin
      region = fsag_pkg::RG_RSVD;
    end else if (addr == fsag_pkg::LOCK_BYTE_ADDR) begin
      region = fsag_pkg::RG_LBYTE;
    end else if (pageIdx == fsag_pkg::LOCK_PAGE) begin
      region = fsag_pkg::RG_LBPAGE;
    end else if (8'(pageIdx) < ~lockByte) begin
      region = fsag_pkg::RG_LOCKED;
    end else begin
      region = fsag_pkg::RG_UNLOCKED;
    end
  end

  // lock page counts as locked once anything is
  assign inLocked = region == fsag_pkg::RG_LOCKED ||
    (anyLocked && (region == fsag_pkg::RG_LBPAGE || region == fsag_pkg::RG_LBYTE));
endmodule
`default_nettype wire

/* core/fsag_reset_pulse.sv */
// stretches a flash-error event into a device reset pulse
// assumes the rest of the chip samples the pulse on ref_clk
`timescale 1ns/1ps
`default_nettype none
module fsag_reset_pulse #(
  parameter int CYC = fsag_pkg::RESET_PULSE_CYC
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic trig,
  output logic pulse
);
  logic [7:0] cntReg;

  // a second event while pulsing is folded into the first
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cntReg <= 8'h00;
      pulse <= 1'b0;
    end else if (trig && !pulse) begin
      cntReg <= 8'(CYC - 1);
      pulse <= 1'b1;
    end else if (cntReg != 8'h00) begin
      cntReg <= cntReg - 8'h01;
    end else begin
      pulse <= 1'b0;
    end
  end
endmodule
`default_nettype wire

/* verif/fsag_flash_model.sv */
// flash array seen from the guard: holds the lock byte, times write/erase
// assumes the guard answers each request one cycle after taking it
`timescale 1ns/1ps
`default_nettype none
module fsag_flash_model #(
  parameter logic [7:0] INIT_LOCK = 8'hfd,
  parameter int BUSY_CYC = 3
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic reqValid,
  input wire logic [1:0] reqOp,
  input wire logic [13:0] reqAddr,
  input wire logic [7:0] reqData,
  input wire logic respPermit,
  input wire logic wholeEraseGo,
  output logic [7:0] lockByteStored,
  output logic flashBusy
);
  // ------------------------------------------------------------
  // array state
  // ------------------------------------------------------------
  // non-volatile: rst leaves the lock byte alone
  logic [1:0] opReg = 2'h0;
  logic [13:0] addrReg = 14'h0000;
  logic [7:0] dataReg = 8'hff;
  int busyCnt = 0;
  logic [7:0] lockMem = INIT_LOCK;
  assign lockByteStored = lockMem;
  assign flashBusy = busyCnt > 0;
  always @(posedge ref_clk) begin
    if (reqValid) begin
      opReg <= reqOp;
      addrReg <= reqAddr;
      dataReg <= reqData;
    end
  end
  always @(posedge ref_clk) begin
    if (wholeEraseGo) begin
      lockMem <= 8'hff;
    end else if (respPermit && opReg == 2'h1 && addrReg == fsag_pkg::LOCK_BYTE_ADDR) begin
      lockMem <= lockMem & dataReg;
    end else if (respPermit && opReg == 2'h2 && addrReg[13:9] == fsag_pkg::LOCK_PAGE) begin
      lockMem <= 8'hff;
    end
  end
  // writes and erases keep the array busy a few cycles
  always @(posedge ref_clk) begin
    if (respPermit && opReg != 2'h0) begin
      busyCnt <= BUSY_CYC;
    end else if (busyCnt > 0) begin
      busyCnt <= busyCnt - 1;
    end
  end
endmodule
`default_nettype wire

/* verif/tb_top.sv */
// self-checking bench for the flash security access guard
// assumes the flash model starts with two pages locked
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  typedef struct packed {
    logic dbg;
    logic [1:0] op;
    logic [13:0] addr;
    logic [13:0] fetch;
    logic [7:0] data;
    logic [3:0] en;
    logic [1:0] exp;
  } fsag_row_t;
  localparam logic [1:0] P = 2'h2;
  localparam logic [1:0] D = 2'h1;
  localparam logic [1:0] F = 2'h0;
  // en: store enables high pair, supply monitor low pair
  localparam fsag_row_t ROWS [0:33] = '{
    '{1'b1, 2'h0, 14'h0400, 14'h0800, 8'hff, 4'h0, P},
    '{1'b0, 2'h0, 14'h0400, 14'h0800, 8'hff, 4'h0, P},
    '{1'b0, 2'h1, 14'h0500, 14'h0100, 8'hff, 4'h7, P},
    '{1'b1, 2'h0, 14'h0000, 14'h0800, 8'hff, 4'h0, D},
    '{1'b0, 2'h0, 14'h0000, 14'h0800, 8'hff, 4'h0, F},
    '{1'b0, 2'h0, 14'h0200, 14'h0100, 8'hff, 4'h0, P},
    '{1'b1, 2'h1, 14'h3c00, 14'h0800, 8'hff, 4'h0, D},
    '{1'b0, 2'h0, 14'h3c10, 14'h0800, 8'hff, 4'h0, F},
    '{1'b0, 2'h1, 14'h3c10, 14'h0100, 8'h00, 4'h7, P},
    '{1'b1, 2'h0, 14'h3dff, 14'h0800, 8'hff, 4'h0, D},
    '{1'b0, 2'h0, 14'h3dff, 14'h0800, 8'hff, 4'h0, F},
    '{1'b0, 2'h0, 14'h3dff, 14'h0100, 8'hff, 4'h0, P},
    '{1'b0, 2'h2, 14'h3c00, 14'h0100, 8'hff, 4'hf, F},
    '{1'b1, 2'h2, 14'h3c00, 14'h0800, 8'hff, 4'h0, D},
    '{1'b0, 2'h1, 14'h3dff, 14'h0100, 8'hf0, 4'h7, F},
    '{1'b1, 2'h1, 14'h3dff, 14'h0800, 8'hf0, 4'h0, D},
    '{1'b1, 2'h1, 14'h3dff, 14'h0800, 8'hff, 4'h0, D},
    '{1'b0, 2'h1, 14'h3dff, 14'h0100, 8'hff, 4'h7, F},
    '{1'b1, 2'h0, 14'h3e00, 14'h0800, 8'hff, 4'h0, D},
    '{1'b0, 2'h0, 14'h3fff, 14'h0100, 8'hff, 4'h0, F},
    '{1'b0, 2'h1, 14'h3e80, 14'h0100, 8'hff, 4'h7, F},
    '{1'b0, 2'h1, 14'h0500, 14'h0100, 8'hff, 4'h5, F},
    '{1'b0, 2'h1, 14'h0500, 14'h0100, 8'hff, 4'h3, D},
    '{1'b1, 2'h3, 14'h0000, 14'h0800, 8'hff, 4'h0, P},
    '{1'b1, 2'h0, 14'h0000, 14'h0800, 8'hff, 4'h0, P},
    '{1'b0, 2'h2, 14'h3c00, 14'h0800, 8'hff, 4'hf, F},
    '{1'b0, 2'h2, 14'h3c00, 14'h0100, 8'hff, 4'hf, F},
    '{1'b1, 2'h2, 14'h3c00, 14'h0800, 8'hff, 4'h0, P},
    '{1'b1, 2'h0, 14'h3dff, 14'h0800, 8'hff, 4'h0, P},
    '{1'b0, 2'h1, 14'h3c00, 14'h0800, 8'hff, 4'h7, P},
    '{1'b0, 2'h1, 14'h3dff, 14'h0800, 8'hfe, 4'h7, P},
    '{1'b0, 2'h0, 14'h0000, 14'h0800, 8'hff, 4'h0, P},
    '{1'b0, 2'h1, 14'h3dff, 14'h0800, 8'hfc, 4'h7, F},
    '{1'b0, 2'h0, 14'h0000, 14'h0800, 8'hff, 4'h0, F}
  };
  logic ref_clk, rst;
  logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [1:0] s_axi_bresp, s_axi_rresp, reqOp, rs;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic reqValid, reqFromDebug, flashBusy, respValid, respPermit, respDrop, wholeEraseGo, irqHold, deviceReset;
  logic [13:0] reqAddr, fetchAddr;
  logic [7:0] reqData, lockByteStored;
  logic busyPrev = 1'b0;
  int failures = 0;
  int comparisons = 0;
  int cycles = 0;
  int n;
  fsag_guard dut (.*);
  fsag_flash_model partner (.*);
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("comparisons=%0d failures=%0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic axiWrite(input logic [3:0] a, input logic [31:0] d);
    logic aw;
    logic w;
    aw = 1'b0;
    w = 1'b0;
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw && w)) begin
      @(posedge ref_clk);
      if (s_axi_awready && !aw) begin
        aw = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wready && !w) begin
        w = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge ref_clk); while (!s_axi_bvalid);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic axiRead(input logic [3:0] a);
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge ref_clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge ref_clk); while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  // enables are rewritten per row since a device reset clears them
  task automatic runRow(input fsag_row_t r);
    axiWrite(fsag_pkg::OFF_STORE_CTL, {30'h0, r.en[3:2]});
    axiWrite(fsag_pkg::OFF_RSRC, {30'h0, r.en[1:0]});
    @(posedge ref_clk);
    reqValid <= 1'b1;
    reqFromDebug <= r.dbg;
    reqOp <= r.op;
    reqAddr <= r.addr;
    fetchAddr <= r.fetch;
    reqData <= r.data;
    @(posedge ref_clk);
    reqValid <= 1'b0;
    @(negedge ref_clk);
    check({respValid, respPermit, respDrop}, {1'b1, r.exp});
    check(deviceReset, r.exp == F);
    check(wholeEraseGo, r.op == 2'h3 && r.exp == P);
    n = 0;
    while (deviceReset) begin
      n++;
      @(negedge ref_clk);
    end
    if (r.exp == F) check(n, fsag_pkg::RESET_PULSE_CYC);
    while (flashBusy) @(negedge ref_clk);
  endtask
  // ------------------------------------------------------------
  // monitors and run
  // ------------------------------------------------------------
  always @(posedge ref_clk) busyPrev <= flashBusy;
  always @(negedge ref_clk) if (!rst) check(irqHold, busyPrev);
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      tally_and_finish;
    end
  end
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  initial begin
    rst = 1'b1;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hf;
    {reqValid, reqFromDebug, reqOp, reqAddr, fetchAddr, reqData} = '0;
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    axiRead(fsag_pkg::OFF_STORE_CTL);
    check(rd, 32'h0);
    axiRead(fsag_pkg::OFF_RSRC);
    check(rd, 32'h0);
    axiRead(4'hc);
    check({rd, rs}, {32'h0, fsag_pkg::RESP_SLVERR});
    axiWrite(4'hc, 32'h3);
    check(rs, fsag_pkg::RESP_SLVERR);
    axiWrite(fsag_pkg::OFF_STORE_CTL, 32'h1);
    axiRead(fsag_pkg::OFF_STORE_CTL);
    check(rd, 32'h1);
    axiRead(fsag_pkg::OFF_STAT);
    check(rd, 32'h1fdfd);
    for (int i = 0; i < 34; i++) begin
      runRow(ROWS[i]);
    end
    axiRead(fsag_pkg::OFF_RSRC);
    check(rd, 32'h40);
    // mid-run reset: stored lock reloads, flag clears
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    axiRead(fsag_pkg::OFF_STAT);
    check(rd, 32'h1fefe);
    axiRead(fsag_pkg::OFF_RSRC);
    check(rd, 32'h0);
    tally_and_finish;
  end
endmodule
`default_nettype wire
